// *** pkg/gtm_consts.svh ***
// Purpose: offsets, field positions and reset values of the timer halves
// Assumes: 32-bit apb data, one aligned word per register
// Notes: included by bare name from the design and the testbench
`ifndef GTM_CONSTS_SVH
`define GTM_CONSTS_SVH

// register byte offsets
`define GTM_OFF_CFG 12'h000
`define GTM_OFF_MODE_A 12'h004
`define GTM_OFF_MODE_B 12'h008
`define GTM_OFF_CTL 12'h00c
`define GTM_OFF_IMR 12'h018
`define GTM_OFF_RIS 12'h01c
`define GTM_OFF_MIS 12'h020
`define GTM_OFF_ICR 12'h024
`define GTM_OFF_ILR_A 12'h028
`define GTM_OFF_ILR_B 12'h02c
`define GTM_OFF_MATCH_A 12'h030
`define GTM_OFF_MATCH_B 12'h034
`define GTM_OFF_PR_A 12'h038
`define GTM_OFF_PR_B 12'h03c
`define GTM_OFF_TR_A 12'h048
`define GTM_OFF_TR_B 12'h04c

// configuration value for two independent 16-bit halves
`define GTM_CFG_16BIT 3'h4
// timer mode field codes
`define GTM_MODE_ONESHOT 2'h1
`define GTM_MODE_PERIODIC 2'h2
`define GTM_MODE_CAPTURE 2'h3
// event select codes
`define GTM_EVT_RISE 2'h0
`define GTM_EVT_FALL 2'h1
`define GTM_EVT_BOTH 2'h3

// control half stride and status bit positions inside a half
`define GTM_HALF_STRIDE 8
`define GTM_RIS_TO 0
`define GTM_RIS_CM 1
`define GTM_RIS_CE 2

// reset values
`define GTM_RST_CNT 16'hffff
`define GTM_RST_ILR 16'hffff
`define GTM_RST_PR 8'h00
`define GTM_RST_MATCH 16'h0000

`endif

// *** pkg/gtm_pkg.sv ***
// Purpose: shared types of the timer halves
// Assumes: constants come from gtm_consts.svh
// Notes: states are one-hot
package gtm_pkg;
    // timer half mode register layout
    typedef struct packed {
        logic alt_mode;      // alternate mode select bit
        logic capture_mode;  // capture mode bit
        logic [1:0] mode;    // timer mode field
    } gtm_mode_s;

    // one half of the timer control register
    typedef struct packed {
        logic pwm_invert;    // pwm output invert bit
        logic adc_trig_en;   // adc trigger enable bit
        logic [1:0] rsvd;    // reads zero
        logic [1:0] event_sel;
        logic stall;         // debug stall bit
        logic en;            // timer half enable bit
    } gtm_ctl_s;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } gtm_apb_req_s;

    // operating state of one half
    typedef enum logic [4:0] {
        GTM_OP_IDLE = 5'h01,
        GTM_OP_TIMER = 5'h02,
        GTM_OP_ECOUNT = 5'h04,
        GTM_OP_ETIME = 5'h08,
        GTM_OP_PWM = 5'h10
    } gtm_op_e;
endpackage

// *** src/gtm_timer16.sv ***
// Purpose: two independent 16-bit timer halves behind an apb slave
// Assumes: ccp inputs and debug_halt are synchronous to clk
// Notes: pready is always high; reads answer in the access cycle
`timescale 1ns/100ps
`default_nettype none
`include "gtm_consts.svh"

// Contract
// RL1: config value 4 selects two 16-bit halves
// RL2: timer modes: 16-bit down-counter with prescaler
// RL3: each decrement spans prescale plus one clocks
// RL4: count down, reload load and prescale after zero
// RL5: one-shot stops and clears enable; periodic continues
// RL6: timeout sets raw flag until software clears
// RL7: unmasked timeout sets masked flag and interrupt
// RL8: adc trigger pulses only when enabled
// RL9: load write while running reloads counter next cycle
// RL10: stall bit freezes counting during debug halt
// RL11: capture input holds each level two clocks
// RL12: no prescaling in edge and pwm modes
// RL13: edge count counts rising, falling or both
// RL14: each edge decrements; match sets match flags
// RL15: after match reload, clear enable, ignore edges
// RL16: edge time free-runs from load, one edge kind
// RL17: selected edge captures count, sets event flags
// RL18: edge time keeps running, reloads at zero
// RL19: captured count holds until next selected edge
// RL20: pwm is alt one, capture zero, mode two
// RL21: pwm reloads after zero, raises no flags
// RL22: pwm asserts at start, deasserts at match, invertible
// RL23: mode one is one-shot, two periodic
// RL24: mode three with capture bit selects edge kind
// RL25: capture pin synchronised, one pulse per edge
// RL26: halves keep fully separate state
module gtm_timer16 (
    input wire logic clk,
    input wire logic rst,
    input wire gtm_pkg::gtm_apb_req_s apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic debug_halt,
    input wire logic [1:0] ccp_in,
    output logic [1:0] ccp_out,
    output logic [1:0] ccp_oe,
    output logic [1:0] adc_trig,
    output logic irq
);

    // decode of one half's operating state
    function automatic gtm_pkg::gtm_op_e op_of(input logic [2:0] cfg_v,
                                               input gtm_pkg::gtm_mode_s m);
        gtm_pkg::gtm_op_e r;
        r = gtm_pkg::GTM_OP_IDLE;
        if (cfg_v == `GTM_CFG_16BIT) begin // [RL1]
            if (m.alt_mode) begin
                if (!m.capture_mode && m.mode == `GTM_MODE_PERIODIC) begin
                    r = gtm_pkg::GTM_OP_PWM; // [RL20]
                end
            end else if (m.mode == `GTM_MODE_ONESHOT ||
                         m.mode == `GTM_MODE_PERIODIC) begin
                r = gtm_pkg::GTM_OP_TIMER; // [RL23]
            end else if (m.mode == `GTM_MODE_CAPTURE) begin
                r = m.capture_mode ? gtm_pkg::GTM_OP_ETIME
                                   : gtm_pkg::GTM_OP_ECOUNT; // [RL24]
            end
        end
        return r;
    endfunction

    logic [2:0] cfg;                  // module configuration register
    gtm_pkg::gtm_mode_s mode_r [2];   // timer half mode registers
    gtm_pkg::gtm_ctl_s ctl_r [2];     // timer control register halves
    logic [15:0] ilr [2];             // interval load registers
    logic [15:0] match_r [2];         // match registers
    logic [7:0] pr [2];               // prescale registers
    logic [15:0] cnt [2];             // live counters
    logic [7:0] ps [2];               // prescale counters
    logic [15:0] cap [2];             // captured counts
    logic [1:0] pwm_lvl;              // uninverted pwm level
    logic [15:0] imr;                 // interrupt mask register
    logic [15:0] ris;                 // raw interrupt status register
    logic [15:0] set_v;               // status set requests this cycle
    logic [1:0] sync1, sync2, sync3;  // capture pin synchroniser
    logic [1:0] rise, fall;           // one-cycle edge events
    gtm_pkg::gtm_op_e op [2];         // per-half operating state
    logic [1:0] tick;                 // half may count this cycle
    logic [1:0] ecnt_edge, etime_edge;
    logic [1:0] tmo, cmatch, cevent;  // per-half events
    logic [1:0] ilr_wr;               // load register write strobes
    logic wr, rd_setup;
    logic [31:0] rdata;
    logic hit;

    // apb strobes: writes land in the access cycle
    assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign rd_setup = apb_req.psel & ~apb_req.penable;
    assign pready = 1'b1;
    assign ilr_wr[0] = wr && apb_req.paddr == `GTM_OFF_ILR_A;
    assign ilr_wr[1] = wr && apb_req.paddr == `GTM_OFF_ILR_B;

    // capture pin synchroniser; first stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1 <= 2'h0;
            sync2 <= 2'h0;
            sync3 <= 2'h0;
        end else begin
            sync1 <= ccp_in; // [RL25]
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end
    // edges need the level held two clocks by the source [RL11]
    assign rise = sync2 & ~sync3; // [RL25]
    assign fall = ~sync2 & sync3;

    // per-half event decode, each half sees only its own state
    always_comb begin
        set_v = 16'h0000;
        for (int i = 0; i < 2; i++) begin
            op[i] = op_of(cfg, mode_r[i]); // [RL26]
            // frozen while stalled under a debug halt
            tick[i] = ctl_r[i].en & ~(ctl_r[i].stall & debug_halt); // [RL10]
            case (ctl_r[i].event_sel) // [RL13]
                `GTM_EVT_FALL: ecnt_edge[i] = fall[i];
                `GTM_EVT_BOTH: ecnt_edge[i] = rise[i] | fall[i];
                default: ecnt_edge[i] = rise[i];
            endcase
            // both-edge code falls back to rising: one kind only
            etime_edge[i] = (ctl_r[i].event_sel == `GTM_EVT_FALL) ?
                            fall[i] : rise[i]; // [RL16]
            tmo[i] = tick[i] && op[i] == gtm_pkg::GTM_OP_TIMER &&
                     ps[i] == 8'h00 && cnt[i] == 16'h0000 &&
                     !ilr_wr[i]; // [RL4]
            cmatch[i] = tick[i] && op[i] == gtm_pkg::GTM_OP_ECOUNT &&
                        ecnt_edge[i] && !ilr_wr[i] &&
                        (cnt[i] - 16'h0001) == match_r[i]; // [RL14]
            cevent[i] = tick[i] && op[i] == gtm_pkg::GTM_OP_ETIME &&
                        etime_edge[i]; // [RL17]
            // pwm contributes nothing here [RL21]
            set_v[i * `GTM_HALF_STRIDE + `GTM_RIS_TO] = tmo[i]; // [RL6]
            set_v[i * `GTM_HALF_STRIDE + `GTM_RIS_CM] = cmatch[i];
            set_v[i * `GTM_HALF_STRIDE + `GTM_RIS_CE] = cevent[i];
        end
    end

    // counters, prescalers, capture and pwm level
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 2; i++) begin
                cnt[i] <= `GTM_RST_CNT;
                ps[i] <= `GTM_RST_PR;
                cap[i] <= `GTM_RST_CNT;
            end
            pwm_lvl <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (cevent[i]) begin
                    cap[i] <= cnt[i]; // [RL17] [RL19]
                end
                if (ilr_wr[i]) begin
                    // new load value takes over at once
                    cnt[i] <= apb_req.pwdata[15:0]; // [RL9]
                    ps[i] <= pr[i];
                end else if (tick[i]) begin
                    case (op[i])
                        gtm_pkg::GTM_OP_TIMER: begin
                            if (ps[i] != 8'h00) begin
                                ps[i] <= ps[i] - 8'h01; // [RL3]
                            end else if (cnt[i] == 16'h0000) begin
                                cnt[i] <= ilr[i]; // [RL4]
                                ps[i] <= pr[i];
                            end else begin
                                cnt[i] <= cnt[i] - 16'h0001; // [RL2]
                                ps[i] <= pr[i];
                            end
                        end
                        gtm_pkg::GTM_OP_ECOUNT: begin
                            // no prescaling outside timer modes [RL12]
                            if (cmatch[i]) begin
                                cnt[i] <= ilr[i]; // [RL15]
                            end else if (ecnt_edge[i]) begin
                                cnt[i] <= cnt[i] - 16'h0001; // [RL14]
                            end
                        end
                        gtm_pkg::GTM_OP_ETIME, gtm_pkg::GTM_OP_PWM: begin
                            if (cnt[i] == 16'h0000) begin
                                cnt[i] <= ilr[i]; // [RL18] [RL21]
                            end else begin
                                cnt[i] <= cnt[i] - 16'h0001;
                            end
                        end
                        default: begin
                            cnt[i] <= cnt[i];
                        end
                    endcase
                end
                // start value wins if start and match coincide
                if (tick[i] && op[i] == gtm_pkg::GTM_OP_PWM) begin
                    if (cnt[i] == ilr[i]) begin
                        pwm_lvl[i] <= 1'b1; // [RL22]
                    end else if (cnt[i] == match_r[i]) begin
                        pwm_lvl[i] <= 1'b0; // [RL22]
                    end
                end
            end
        end
    end

    // pin outputs and trigger pulses, all from flops
    always_ff @(posedge clk) begin
        if (rst) begin
            ccp_out <= 2'h0;
            ccp_oe <= 2'h0;
            adc_trig <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                ccp_oe[i] <= op[i] == gtm_pkg::GTM_OP_PWM;
                ccp_out[i] <= (op[i] == gtm_pkg::GTM_OP_PWM) &
                              (pwm_lvl[i] ^ ctl_r[i].pwm_invert); // [RL22]
                adc_trig[i] <= tmo[i] & ctl_r[i].adc_trig_en; // [RL8]
            end
        end
    end

    // control register; hardware clears of enable follow the write
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_r[0] <= '0;
            ctl_r[1] <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr && apb_req.paddr == `GTM_OFF_CTL) begin
                    ctl_r[i] <= apb_req.pwdata[i * 8 +: 8];
                    ctl_r[i].rsvd <= 2'h0;
                end
                if ((tmo[i] && mode_r[i].mode == `GTM_MODE_ONESHOT) ||
                    cmatch[i]) begin
                    ctl_r[i].en <= 1'b0; // [RL5] [RL15]
                end
            end
        end
    end

    // configuration, mode, load, match, prescale and mask registers
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg <= 3'h0;
            imr <= 16'h0000;
            for (int i = 0; i < 2; i++) begin
                mode_r[i] <= '0;
                ilr[i] <= `GTM_RST_ILR;
                match_r[i] <= `GTM_RST_MATCH;
                pr[i] <= `GTM_RST_PR;
            end
        end else if (wr) begin
            if (apb_req.paddr == `GTM_OFF_CFG) begin
                cfg <= apb_req.pwdata[2:0];
            end else if (apb_req.paddr == `GTM_OFF_MODE_A) begin
                mode_r[0] <= apb_req.pwdata[3:0];
            end else if (apb_req.paddr == `GTM_OFF_MODE_B) begin
                mode_r[1] <= apb_req.pwdata[3:0];
            end else if (apb_req.paddr == `GTM_OFF_IMR) begin
                imr <= apb_req.pwdata[15:0] & 16'h0707;
            end else if (apb_req.paddr == `GTM_OFF_ILR_A) begin
                ilr[0] <= apb_req.pwdata[15:0];
            end else if (apb_req.paddr == `GTM_OFF_ILR_B) begin
                ilr[1] <= apb_req.pwdata[15:0];
            end else if (apb_req.paddr == `GTM_OFF_MATCH_A) begin
                match_r[0] <= apb_req.pwdata[15:0];
            end else if (apb_req.paddr == `GTM_OFF_MATCH_B) begin
                match_r[1] <= apb_req.pwdata[15:0];
            end else if (apb_req.paddr == `GTM_OFF_PR_A) begin
                pr[0] <= apb_req.pwdata[7:0];
            end else if (apb_req.paddr == `GTM_OFF_PR_B) begin
                pr[1] <= apb_req.pwdata[7:0];
            end
        end
    end

    // raw status: a set in the clearing cycle survives
    always_ff @(posedge clk) begin
        if (rst) begin
            ris <= 16'h0000;
        end else if (wr && apb_req.paddr == `GTM_OFF_ICR) begin
            ris <= (ris & ~apb_req.pwdata[15:0]) | set_v; // [RL6]
        end else begin
            ris <= ris | set_v; // [RL6]
        end
    end

    // interrupt request from masked status
    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |((ris | set_v) & imr); // [RL7]
        end
    end

    // read mux; timer register shows capture only in edge time
    always_comb begin
        rdata = 32'h0000_0000;
        hit = 1'b1;
        if (apb_req.paddr == `GTM_OFF_CFG) begin
            rdata = {29'h0, cfg};
        end else if (apb_req.paddr == `GTM_OFF_MODE_A) begin
            rdata = {28'h0, mode_r[0]};
        end else if (apb_req.paddr == `GTM_OFF_MODE_B) begin
            rdata = {28'h0, mode_r[1]};
        end else if (apb_req.paddr == `GTM_OFF_CTL) begin
            rdata = {16'h0, ctl_r[1], ctl_r[0]};
        end else if (apb_req.paddr == `GTM_OFF_IMR) begin
            rdata = {16'h0, imr};
        end else if (apb_req.paddr == `GTM_OFF_RIS) begin
            rdata = {16'h0, ris};
        end else if (apb_req.paddr == `GTM_OFF_MIS) begin
            rdata = {16'h0, ris & imr}; // [RL7]
        end else if (apb_req.paddr == `GTM_OFF_ICR) begin
            rdata = 32'h0000_0000;
        end else if (apb_req.paddr == `GTM_OFF_ILR_A) begin
            rdata = {16'h0, ilr[0]};
        end else if (apb_req.paddr == `GTM_OFF_ILR_B) begin
            rdata = {16'h0, ilr[1]};
        end else if (apb_req.paddr == `GTM_OFF_MATCH_A) begin
            rdata = {16'h0, match_r[0]};
        end else if (apb_req.paddr == `GTM_OFF_MATCH_B) begin
            rdata = {16'h0, match_r[1]};
        end else if (apb_req.paddr == `GTM_OFF_PR_A) begin
            rdata = {24'h0, pr[0]};
        end else if (apb_req.paddr == `GTM_OFF_PR_B) begin
            rdata = {24'h0, pr[1]};
        end else if (apb_req.paddr == `GTM_OFF_TR_A) begin
            rdata = {16'h0, (op[0] == gtm_pkg::GTM_OP_ETIME) ?
                     cap[0] : cnt[0]}; // [RL19]
        end else if (apb_req.paddr == `GTM_OFF_TR_B) begin
            rdata = {16'h0, (op[1] == gtm_pkg::GTM_OP_ETIME) ?
                     cap[1] : cnt[1]};
        end else begin
            hit = 1'b0;
        end
    end

    // read data and error latched in the setup cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (rd_setup) begin
            prdata <= apb_req.pwrite ? 32'h0000_0000 : rdata;
            pslverr <= ~hit;
        end
    end

    // checks per half
    for (genvar g = 0; g < 2; g++) begin : g_chk
        a_timeout_flag: assert property (@(posedge clk) disable iff (rst)
            tmo[g] |=> ris[g * 8] && cnt[g] == $past(ilr[g])) // [RL4]
            else $error("timeout did not reload or flag");
        a_oneshot_stop: assert property (@(posedge clk) disable iff (rst)
            tmo[g] && mode_r[g].mode == 2'h1 |=> !ctl_r[g].en) // [RL5]
            else $error("one-shot kept its enable");
        a_prescale_hold: assert property (@(posedge clk) disable iff (rst)
            tick[g] && op[g] == gtm_pkg::GTM_OP_TIMER && ps[g] != 8'h00 &&
            !ilr_wr[g] |=> cnt[g] == $past(cnt[g])) // [RL3]
            else $error("counter moved inside a prescale period");
        a_stall_freeze: assert property (@(posedge clk) disable iff (rst)
            ctl_r[g].stall && debug_halt && !ilr_wr[g] |=>
            cnt[g] == $past(cnt[g]) && ps[g] == $past(ps[g])) // [RL10]
            else $error("counter moved during debug stall");
        a_adc_trig: assert property (@(posedge clk) disable iff (rst)
            adc_trig[g] == $past(tmo[g] & ctl_r[g].adc_trig_en)) // [RL8]
            else $error("adc trigger mismatch");
        a_match_stop: assert property (@(posedge clk) disable iff (rst)
            cmatch[g] |=> ris[g * 8 + 1] && !ctl_r[g].en &&
            cnt[g] == $past(ilr[g])) // [RL15]
            else $error("edge count match not handled");
        a_capture_take: assert property (@(posedge clk) disable iff (rst)
            cevent[g] |=> cap[g] == $past(cnt[g]) && ris[g * 8 + 2]) // [RL17]
            else $error("capture missed the count");
        a_pwm_silent: assert property (@(posedge clk) disable iff (rst)
            op[g] == gtm_pkg::GTM_OP_PWM |-> set_v[g * 8 +: 3] == 3'h0)
            else $error("pwm raised a status flag"); // [RL21]
        a_pwm_level: assert property (@(posedge clk) disable iff (rst)
            tick[g] && op[g] == gtm_pkg::GTM_OP_PWM && cnt[g] == ilr[g]
            |=> ##1 ccp_out[g] == !ctl_r[g].pwm_invert) // [RL22]
            else $error("pwm did not assert at start value");
    end

    a_load_write: assert property (@(posedge clk) disable iff (rst)
        ilr_wr[0] |=> cnt[0] == $past(apb_req.pwdata[15:0])) // [RL9]
        else $error("load write did not reach the counter");

endmodule
`default_nettype wire

// *** testbench/gtm_pin_model.sv ***
// Purpose: capture pin source standing in for the outside signal
// Assumes: runs on the bench clock, levels change after a rising edge
// Notes: levels held four clocks, twice the minimum, so edges are legal
`timescale 1ns/100ps
`default_nettype none
module gtm_pin_model (
    input wire logic clk,
    output logic [1:0] pin_drv
);
    // both pins rest low until a pulse is asked for
    initial pin_drv = 2'h0;
    // whole pulses on one pin, each level held four clocks
    task pulse(input int idx, input int n);
        repeat (n) begin
            @(posedge clk);
            pin_drv[idx[0]] <= 1'b1;
            repeat (4) @(posedge clk);
            pin_drv[idx[0]] <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// Purpose: self-checking bench for the two 16-bit timer halves
// Assumes: apb slave answers with pready, one register per word
// Notes: each scenario is a task that drives and judges by itself
`timescale 1ns/100ps
`default_nettype none
`include "gtm_consts.svh"
module testbench;
    logic clk = 1'b0; // 125 MHz system clock
    logic rst = 1'b1; // synchronous, active high
    logic halt = 1'b0; // debugger halt level
    gtm_pkg::gtm_apb_req_s req = '0; // apb request bundle
    logic [31:0] prdata, rq; // read data, scratch copy
    logic pready, pslverr, irq, re;
    logic [1:0] ccp_out, ccp_oe, adc_trig, pin_drv, pin;
    int err_total = 0;
    int comparisons = 0;
    int cyc = 0; // free cycle count for capture distances
    // pin level: the timer wins while it drives, else the outside source
    assign pin = (ccp_oe & ccp_out) | (~ccp_oe & pin_drv);
    gtm_timer16 i_dut (.clk(clk), .rst(rst), .apb_req(req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .debug_halt(halt), .ccp_in(pin),
        .ccp_out(ccp_out), .ccp_oe(ccp_oe), .adc_trig(adc_trig), .irq(irq));
    gtm_pin_model i_pin (.clk(clk), .pin_drv(pin_drv));
    always #4 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    // compare one value and count it
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
            err_total++;
        end
    endtask
    // one apb transfer; held until pready is seen at an edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        req <= '0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rq, re);
    endtask
    task rc(input string n, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, rq, re);
        chk(n, e, rq);
    endtask
    // cycles to the next trigger pulse of a half, capped at 2000
    task gap(input int i, output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (adc_trig[i] !== 1'b1 && c < 2000);
    endtask
    task s_reset();
        rc("load a", `GTM_OFF_ILR_A, 32'h0000ffff);
        rc("count a", `GTM_OFF_TR_A, 32'h0000ffff);
        apb(1'b0, 12'h0f0, 32'h0, rq, re);
        chk("unmapped err", 32'h1, {31'h0, re});
    endtask
    // periodic then one-shot on the first half
    task s_timer();
        int c;
        wr(`GTM_OFF_CFG, 32'h4);
        wr(`GTM_OFF_MODE_A, 32'h2);
        wr(`GTM_OFF_PR_A, 32'h1);
        wr(`GTM_OFF_ILR_A, 32'h2);
        wr(`GTM_OFF_IMR, 32'h1);
        wr(`GTM_OFF_CTL, 32'h41);
        gap(0, c);
        gap(0, c);
        chk("period", 32'h6, c);
        chk("irq", 32'h1, {31'h0, irq});
        wr(`GTM_OFF_CTL, 32'h0);
        rc("masked", `GTM_OFF_MIS, 32'h1);
        wr(`GTM_OFF_ICR, 32'h1);
        rc("cleared", `GTM_OFF_RIS, 32'h0);
        chk("irq low", 32'h0, {31'h0, irq});
        wr(`GTM_OFF_MODE_A, 32'h1);
        wr(`GTM_OFF_ILR_A, 32'h2);
        wr(`GTM_OFF_CTL, 32'h1);
        gap(0, c);
        chk("no trigger", 32'd2000, c);
        rc("oneshot off", `GTM_OFF_CTL, 32'h0);
        rc("oneshot flag", `GTM_OFF_RIS, 32'h1);
        rc("reload", `GTM_OFF_TR_A, 32'h2);
    endtask
    // big prescale keeps the count still long enough to read it exactly
    task s_stall();
        wr(`GTM_OFF_MODE_A, 32'h2);
        wr(`GTM_OFF_PR_A, 32'hff);
        wr(`GTM_OFF_CTL, 32'h3);
        wr(`GTM_OFF_ILR_A, 32'h1234);
        rc("load on the fly", `GTM_OFF_TR_A, 32'h1234);
        halt <= 1'b1;
        repeat (600) @(posedge clk);
        rc("frozen", `GTM_OFF_TR_A, 32'h1234);
        halt <= 1'b0;
        repeat (600) @(posedge clk);
        rc("resumed", `GTM_OFF_TR_A, 32'h1232);
        wr(`GTM_OFF_CTL, 32'h0);
    endtask
    // one pulse is two edges only when both kinds count
    task s_ecount();
        logic [1:0] ev[3] = '{2'h0, 2'h1, 2'h3};
        wr(`GTM_OFF_MODE_A, 32'h3);
        wr(`GTM_OFF_MATCH_A, 32'h2);
        foreach (ev[k]) begin
            wr(`GTM_OFF_CTL, {28'h0, ev[k], 2'h0});
            wr(`GTM_OFF_ICR, 32'h7);
            wr(`GTM_OFF_ILR_A, 32'h4);
            wr(`GTM_OFF_CTL, {28'h0, ev[k], 2'h1});
            i_pin.pulse(0, 1);
            rc("one pulse", `GTM_OFF_RIS, {30'h0, ev[k] == 2'h3, 1'b0});
            i_pin.pulse(0, 1);
            rc("match", `GTM_OFF_RIS, 32'h2);
            rc("self stop", `GTM_OFF_CTL, {28'h0, ev[k], 2'h0});
            rc("reloaded", `GTM_OFF_TR_A, 32'h4);
        end
    endtask
    // prescale left at 0xff: capture distance must still be in clocks
    task s_etime();
        int t;
        logic [31:0] c1;
        wr(`GTM_OFF_ICR, 32'h7);
        wr(`GTM_OFF_MODE_A, 32'h7);
        wr(`GTM_OFF_ILR_A, 32'hffff);
        wr(`GTM_OFF_CTL, 32'h1);
        i_pin.pulse(0, 1);
        t = cyc;
        apb(1'b0, `GTM_OFF_TR_A, 32'h0, c1, re);
        rc("held capture", `GTM_OFF_TR_A, c1);
        rc("event flag", `GTM_OFF_RIS, 32'h4);
        i_pin.pulse(0, 1);
        rc("no prescale", `GTM_OFF_TR_A, c1 - (cyc - t));
        wr(`GTM_OFF_CTL, 32'h0);
    endtask
    // second half, plain and inverted duty over one period of ten
    task s_pwm();
        int hi;
        wr(`GTM_OFF_ICR, 32'h707);
        wr(`GTM_OFF_MODE_B, 32'ha);
        wr(`GTM_OFF_ILR_B, 32'h9);
        wr(`GTM_OFF_MATCH_B, 32'h3);
        for (int inv = 0; inv < 2; inv++) begin
            wr(`GTM_OFF_CTL, {16'h0, inv[0], 1'b0, 6'h1, 8'h0});
            repeat (40) @(posedge clk);
            hi = 0;
            repeat (10) begin
                @(posedge clk);
                hi += (ccp_out[1] === 1'b1);
            end
            chk("duty", inv ? 32'd4 : 32'd6, hi);
            chk("pin driven", 32'h1, {31'h0, ccp_oe[1]});
        end
        rc("no flags", `GTM_OFF_RIS, 32'h0);
        wr(`GTM_OFF_CTL, 32'h0);
    endtask
    task summarize();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // main sequence after three clocks of reset
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        s_reset();
        s_timer();
        s_stall();
        s_ecount();
        s_etime();
        s_pwm();
        summarize();
    end
    // watchdog well past the expected run of about 3600 clocks
    initial begin
        repeat (40000) @(posedge clk);
        err_total++;
        summarize();
    end
endmodule
`default_nettype wire
